// >>> phase_cfg_regs.svh
// Register offsets, field positions, reset values and timing counts
// for the phase configuration and power-good delay register bank.
// Assumes inclusion by bare name from the design, checker and bench files.
`ifndef PHASE_CFG_REGS_SVH
`define PHASE_CFG_REGS_SVH
`define OFS_IIN_CAL 8'hD2
`define OFS_RAIL_CFG 8'hD3
`define OFS_PG_DELAY 8'hD4
`define OFS_RAMP_GAIN 8'hD5
`define RST_IIN_CAL 16'hC200
`define RST_PG_DELAY 16'hBA00
`define RST_RAMP_GAIN 8'h03
`define FLD_PHASE_HI 15
`define FLD_PHASE_LO 13
`define FLD_RAIL_HI 12
`define FLD_RAIL_LO 8
`define FLD_COUNT_HI 2
`define FLD_COUNT_LO 0
`define LIN_EXP_LO 11
`define STEP_NS 125
`define CLK_NS 5
`define TICK_CYCLES (`STEP_NS / `CLK_NS)
`define MAX_DELAY_NS 500000000
`endif

// >>> phase_cfg_pkg.sv
// Types shared by the phase configuration register bank.
// Assumes the register header sits in the same folder.
package phase_cfg_pkg;
  typedef enum logic [1:0] {PG_IDLE, PG_WAIT, PG_GOOD} pg_state_t;
  typedef enum logic [1:0] {DRV_OFF, DRV_RAMP, DRV_ON, DRV_SOFTOFF} drv_state_t;
endpackage

// >>> phase_config_and_pg_delay_regs.sv
// Configuration register bank for a multiphase controller: calibration
// gain, rail/phase assignment, power-good delay and start-up ramp gain.
// Assumes a command decoder on clk_i presents one-cycle write strokes;
// the power-good comparator and enable pin arrive asynchronous and are synchronised; straps are sampled directly.
//
// Summary of operation
// - Input current calibration value held, default C200h meaning two milliohms.
// - Calibration gain is one global sixteen-bit register.
// - Linear words carry signed exponent above, signed mantissa below.
// - Rail word bits 15:13 hold phase position zero to seven.
// - Rail word bits 12:8 hold rail identifier; equal identifiers share current.
// - Rail word bits 2:0 hold phase count minus one; 7:3 unused.
// - Default rail identifier is low five address bits; rest zero.
// - Phase offset spaced equally from position and phase count.
// - Strap preset loads rail word without host write.
// - Power-good pin asserts after programmed delay, 125ns steps up to 500ms.
// - Power-good delay is linear, sixteen bits, default BA00h meaning 1ms.
// - Four-phase group selects multiphase ramp mode automatically.
// - Multiphase ramp keeps fast loop off until power-good asserts.
// - Multiphase ramp skips soft-off and ignores turn-off fall time.
// - Multiphase shutdown floats high-side drive and pulls low-side drive low.
// - Standalone two-phase keeps fast loop on; ramps behave normally.
// - Ramp gain is global byte 00 to FF, default 03h.
// - Lower ramp gain gives longer start-up ramp.
`timescale 1ns/1ps
`include "phase_cfg_regs.svh"

module phase_config_and_pg_delay_regs
  import phase_cfg_pkg::*;
#(
  parameter int unsigned TICK_CYCLES = `TICK_CYCLES,
  parameter int unsigned RAMP_BASE_CYCLES = 4096
) (
  input wire logic clk_i, // 200 MHz clock
  input wire logic resetn_i, // Async reset, active low
  input wire logic wr_en_i, // Command write stroke
  input wire logic [7:0] wr_cmd_i, // Command code
  input wire logic [15:0] wr_data_i, // Write data, low byte for one-byte commands
  input wire logic [7:0] rd_cmd_i, // Read command code
  output logic [15:0] rd_data_o, // Read data
  output logic rd_valid_o, // Read command recognised
  input wire logic [6:0] bus_addr_i, // Device bus address strap
  input wire logic strap_preset_i, // Strap selects a preset rail word
  input wire logic [15:0] strap_rail_cfg_i, // Preset rail word from strap
  input wire logic above_pg_thresh_i, // Output above power-good threshold, async
  input wire logic enable_i, // Output enable request, async
  output logic power_good_pin_o, // Power-good pin level
  output logic fast_adaptive_loop_o, // Fast adaptive loop enable
  output logic multiphase_mode_o, // Multiphase ramp mode active
  output logic soft_off_allowed_o, // Turn-off fall ramp may be used
  output logic high_side_drive_out_o, // High-side drive level when driven
  output logic high_side_drive_oe_o, // High-side drive enable, low drives
  output logic low_side_drive_output_o, // Low-side drive level
  output logic ramp_active_o, // Start-up ramp running
  output logic ramp_step_o, // One-cycle ramp advance pulse
  output logic [2:0] phase_slot_o, // Own phase position
  output logic [3:0] phase_total_o, // Phases in rail
  output logic [15:0] input_current_cal_o // Calibration word for current math
);

  // Registers
  logic [15:0] input_current_cal_gain, next_input_current_cal_gain;
  logic [15:0] rail_phase_config, next_rail_phase_config;
  logic [15:0] pg_assert_delay, next_pg_assert_delay;
  logic [7:0] startup_ramp_gain, next_startup_ramp_gain;
  logic cfg_loaded, next_cfg_loaded;

  // Two-flop synchronisers for the async levels
  logic [1:0] thr_sync, en_sync;
  logic above_s, en_s;
  assign above_s = thr_sync[1];
  assign en_s = en_sync[1];

  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      thr_sync <= 2'h0;
      en_sync <= 2'h0;
    end else begin
      thr_sync <= {thr_sync[0], above_pg_thresh_i};
      en_sync <= {en_sync[0], enable_i};
    end
  end

  // Default rail word: address bits in the rail field, all else zero
  function automatic logic [15:0] rail_default(input logic [6:0] addr);
    logic [15:0] w;
    w = 16'h0000;
    w[`FLD_RAIL_HI:`FLD_RAIL_LO] = addr[4:0];
    return w;
  endfunction

  // Linear word to 125ns tick count, saturating at the range ceiling
  function automatic logic [31:0] lin_to_ticks(input logic [15:0] w);
    logic signed [4:0] e;
    logic signed [10:0] m;
    logic [63:0] ns_val;
    logic [63:0] t;
    e = w[15:`LIN_EXP_LO];
    m = w[`LIN_EXP_LO-1:0];
    t = 64'h0;
    ns_val = 64'h0;
    if (m > 0) begin
      // Value is in ms; scale to ns before the exponent shift
      ns_val = 64'(m) * 64'd1000000;
      if (e >= 0) ns_val = ns_val << e;
      else ns_val = ns_val >> (-e);
      if (ns_val > 64'd`MAX_DELAY_NS) ns_val = 64'd`MAX_DELAY_NS;
      t = ns_val / 64'd`STEP_NS;
    end
    return t[31:0];
  endfunction

  // Register writes; strap preset is captured once after reset release
  always_comb begin
    next_input_current_cal_gain = input_current_cal_gain;
    next_rail_phase_config = rail_phase_config;
    next_pg_assert_delay = pg_assert_delay;
    next_startup_ramp_gain = startup_ramp_gain;
    next_cfg_loaded = 1'b1;
    if (!cfg_loaded) begin
      if (strap_preset_i) next_rail_phase_config = strap_rail_cfg_i;
      else next_rail_phase_config = rail_default(bus_addr_i);
    end else if (wr_en_i) begin
      case (wr_cmd_i)
        `OFS_IIN_CAL: next_input_current_cal_gain = wr_data_i;
        `OFS_RAIL_CFG: next_rail_phase_config = wr_data_i & 16'hFF07;
        `OFS_PG_DELAY: next_pg_assert_delay = wr_data_i;
        `OFS_RAMP_GAIN: next_startup_ramp_gain = wr_data_i[7:0];
        default: ;
      endcase
    end
  end

  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      input_current_cal_gain <= `RST_IIN_CAL;
      rail_phase_config <= 16'h0000;
      pg_assert_delay <= `RST_PG_DELAY;
      startup_ramp_gain <= `RST_RAMP_GAIN;
      cfg_loaded <= 1'b0;
    end else begin
      input_current_cal_gain <= next_input_current_cal_gain;
      rail_phase_config <= next_rail_phase_config;
      pg_assert_delay <= next_pg_assert_delay;
      startup_ramp_gain <= next_startup_ramp_gain;
      cfg_loaded <= next_cfg_loaded;
    end
  end

  // Read mux; unused bits read zero, except rail bits 7:3, which a strap preset loads unmasked
  always_comb begin
    rd_valid_o = 1'b1;
    case (rd_cmd_i)
      `OFS_IIN_CAL: rd_data_o = input_current_cal_gain;
      `OFS_RAIL_CFG: rd_data_o = rail_phase_config;
      `OFS_PG_DELAY: rd_data_o = pg_assert_delay;
      `OFS_RAMP_GAIN: rd_data_o = {8'h00, startup_ramp_gain};
      default: begin
        rd_data_o = 16'h0000;
        rd_valid_o = 1'b0;
      end
    endcase
  end

  // Field decode; phase offset follows position over count
  logic [3:0] n_phases;
  logic multi_mode;
  assign n_phases = {1'b0, rail_phase_config[`FLD_COUNT_HI:`FLD_COUNT_LO]} + 4'h1;
  assign multi_mode = (n_phases == 4'h4);
  assign phase_slot_o = rail_phase_config[`FLD_PHASE_HI:`FLD_PHASE_LO];
  assign phase_total_o = n_phases;
  assign multiphase_mode_o = multi_mode;
  assign input_current_cal_o = input_current_cal_gain;
  assign soft_off_allowed_o = !multi_mode;

  // 125ns tick enable divider
  logic [7:0] tick_cnt, next_tick_cnt;
  logic tick;
  assign tick = (tick_cnt == 8'(TICK_CYCLES - 1));
  always_comb begin
    next_tick_cnt = tick ? 8'h00 : tick_cnt + 8'h01;
  end
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) tick_cnt <= 8'h00;
    else tick_cnt <= next_tick_cnt;
  end

  // Power-good delay machine: restarts whenever the output drops back
  pg_state_t pg_state, next_pg_state;
  logic [31:0] pg_cnt, next_pg_cnt;
  logic [31:0] pg_target;
  logic pg_q, next_pg_q;
  assign pg_target = lin_to_ticks(pg_assert_delay);

  always_comb begin
    next_pg_state = pg_state;
    next_pg_cnt = pg_cnt;
    next_pg_q = 1'b0;
    case (pg_state)
      PG_IDLE: begin
        next_pg_cnt = 32'h0;
        if (above_s) next_pg_state = PG_WAIT;
      end
      PG_WAIT: begin
        if (!above_s) begin
          next_pg_state = PG_IDLE;
        end else if (pg_cnt >= pg_target) begin
          next_pg_state = PG_GOOD;
          next_pg_q = 1'b1;
        end else if (tick) begin
          next_pg_cnt = pg_cnt + 32'h1;
        end
      end
      PG_GOOD: begin
        next_pg_q = above_s;
        if (!above_s) next_pg_state = PG_IDLE;
      end
      default: next_pg_state = PG_IDLE;
    endcase
  end

  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      pg_state <= PG_IDLE;
      pg_cnt <= 32'h0;
      pg_q <= 1'b0;
    end else begin
      pg_state <= next_pg_state;
      pg_cnt <= next_pg_cnt;
      pg_q <= next_pg_q;
    end
  end
  assign power_good_pin_o = pg_q;

  // Ramp pacing: step period shrinks as gain grows, so low gain ramps slower
  logic [31:0] ramp_cnt, next_ramp_cnt;
  logic [31:0] ramp_period;
  logic step;
  assign ramp_period = (startup_ramp_gain == 8'h00) ? RAMP_BASE_CYCLES
                       : RAMP_BASE_CYCLES / {24'h0, startup_ramp_gain};
  assign step = (ramp_cnt + 32'h1 >= ramp_period);

  // Output drive machine
  drv_state_t drv_state, next_drv_state;
  logic fast_q, next_fast_q;
  logic hs_oe_n, next_hs_oe_n;
  logic ls_q, next_ls_q;

  always_comb begin
    next_drv_state = drv_state;
    next_ramp_cnt = 32'h0;
    next_fast_q = !multi_mode;
    next_hs_oe_n = 1'b0;
    next_ls_q = 1'b1;
    case (drv_state)
      DRV_OFF: begin
        next_hs_oe_n = multi_mode; // Floated when off in multiphase
        next_ls_q = 1'b0;
        if (en_s) next_drv_state = DRV_RAMP;
      end
      DRV_RAMP: begin
        next_ramp_cnt = step ? 32'h0 : ramp_cnt + 32'h1;
        if (multi_mode) next_fast_q = 1'b0;
        if (!en_s) next_drv_state = multi_mode ? DRV_OFF : DRV_SOFTOFF;
        else if (pg_q) next_drv_state = DRV_ON;
      end
      DRV_ON: begin
        if (multi_mode) next_fast_q = pg_q;
        if (!en_s) begin
          // Multiphase shutdown is abrupt: no soft-off ramp
          next_drv_state = multi_mode ? DRV_OFF : DRV_SOFTOFF;
          next_hs_oe_n = multi_mode;
          next_ls_q = !multi_mode;
        end
      end
      DRV_SOFTOFF: begin
        // Fall time pacing lives outside; leave once output has dropped
        if (!above_s) next_drv_state = DRV_OFF;
        else if (en_s) next_drv_state = DRV_ON;
      end
      default: next_drv_state = DRV_OFF;
    endcase
  end

  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      drv_state <= DRV_OFF;
      ramp_cnt <= 32'h0;
      fast_q <= 1'b0;
      hs_oe_n <= 1'b1;
      ls_q <= 1'b0;
    end else begin
      drv_state <= next_drv_state;
      ramp_cnt <= next_ramp_cnt;
      fast_q <= next_fast_q;
      hs_oe_n <= next_hs_oe_n;
      ls_q <= next_ls_q;
    end
  end

  assign fast_adaptive_loop_o = fast_q;
  assign high_side_drive_out_o = 1'b0;
  assign high_side_drive_oe_o = hs_oe_n;
  assign low_side_drive_output_o = ls_q;
  assign ramp_active_o = (drv_state == DRV_RAMP);
  assign ramp_step_o = ramp_active_o && step;

endmodule // phase_config_and_pg_delay_regs

// >>> phase_cfg_host.sv
// Host model issuing command writes and reads to the bank.
// Assumes the bank takes writes on the rising clk_i edge.
`timescale 1ns/1ps
module phase_cfg_host (
  input wire logic clk_i, // Clock
  output logic wr_en_o, // Write stroke
  output logic [7:0] wr_cmd_o, // Write code
  output logic [15:0] wr_data_o, // Write data
  output logic [7:0] rd_cmd_o, // Read code
  input wire logic [15:0] rd_data_i // Read data
);
  // Idle bus at time zero
  initial begin
    wr_en_o = 1'b0;
    wr_cmd_o = 8'h00;
    wr_data_o = 16'h0000;
    rd_cmd_o = 8'h00;
  end
  // One stroke; read code follows so readback shows next cycle
  task automatic wr(input logic [7:0] cmd, input logic [15:0] data);
    @(posedge clk_i);
    wr_en_o <= 1'b1;
    wr_cmd_o <= cmd;
    wr_data_o <= data;
    rd_cmd_o <= cmd;
    @(posedge clk_i);
    wr_en_o <= 1'b0;
    wr_cmd_o <= ~cmd; // Released lines must not keep old value
    wr_data_o <= ~data;
  endtask
  // Read is combinational, sampled mid-cycle
  task automatic rd(input logic [7:0] cmd, output logic [15:0] data);
    @(posedge clk_i);
    rd_cmd_o <= cmd;
    @(negedge clk_i);
    data = rd_data_i;
  endtask
  // Rail word: shared rail id, count minus one, own position
  task automatic set_rail(input logic [2:0] pos, input logic [4:0] rail, input logic [2:0] cnt);
    wr(8'hD3, {pos, rail, 5'h00, cnt});
  endtask
endmodule // phase_cfg_host

// >>> phase_cfg_asserts.sv
// Port checker for the phase configuration bank.
// Assumes a bind onto the bank top; sees its ports only.
`timescale 1ns/1ps
`include "phase_cfg_regs.svh"
module phase_cfg_asserts (
  input wire logic clk_i, // Clock
  input wire logic resetn_i, // Reset
  input wire logic [7:0] rd_cmd_i, // Read code
  input wire logic [15:0] rd_data_o, // Read data
  input wire logic above_pg_thresh_i, // Above threshold
  input wire logic enable_i, // Enable
  input wire logic power_good_pin_o, // Power good
  input wire logic fast_adaptive_loop_o, // Fast loop
  input wire logic multiphase_mode_o, // Multiphase
  input wire logic soft_off_allowed_o, // Soft-off
  input wire logic high_side_drive_oe_o, // High-side enable
  input wire logic low_side_drive_output_o, // Low-side level
  input wire logic ramp_active_o, // Ramping
  input wire logic [2:0] phase_slot_o, // Position
  input wire logic [3:0] phase_total_o // Phases
);
  // One domain, so clock and reset are given once
  default clocking @(posedge clk_i);
  endclocking
  default disable iff (!resetn_i);
  // Mode and field decode
  chk_mode_four: assert property (multiphase_mode_o == (phase_total_o == 4'h4))
    else $error("multiphase mode wrong");
  chk_soft_off: assert property (soft_off_allowed_o == !multiphase_mode_o)
    else $error("soft-off permission wrong");
  chk_rail_fields: assert property (rd_cmd_i == `OFS_RAIL_CFG |->
    phase_slot_o == rd_data_o[15:13] && rd_data_o[7:3] == 5'h00
    && phase_total_o == {1'b0, rd_data_o[2:0]} + 4'h1)
    else $error("rail fields wrong");
  chk_gain_byte: assert property (
    rd_cmd_i == `OFS_RAMP_GAIN |-> rd_data_o[15:8] == 8'h00)
    else $error("gain upper byte set");
  // Power good follows a held threshold; async input costs two sync stages
  chk_pg_drop: assert property (!above_pg_thresh_i [*5] |-> !power_good_pin_o)
    else $error("power good high while below");
  chk_pg_early: assert property (
    $rose(power_good_pin_o) |-> $past(above_pg_thresh_i, 2))
    else $error("power good without threshold");
  // Drive state on shutdown and fast loop gating
  chk_mp_shutdown: assert property ($fell(enable_i) && multiphase_mode_o |->
    ##[1:8] (high_side_drive_oe_o && !low_side_drive_output_o))
    else $error("multiphase shutdown drive wrong");
  chk_std_loop: assert property (!multiphase_mode_o [*3] |-> fast_adaptive_loop_o)
    else $error("standalone fast loop off");
  chk_ramp_loop: assert property (
    multiphase_mode_o && $past(multiphase_mode_o) && ramp_active_o |-> !fast_adaptive_loop_o)
    else $error("fast loop on during multiphase ramp");
  // Main scenarios reached
  cov_pg_rise: cover property ($rose(power_good_pin_o));
  cov_mp_ramp: cover property (multiphase_mode_o && ramp_active_o);
  cov_soft_off: cover property (!multiphase_mode_o && $fell(enable_i));
endmodule // phase_cfg_asserts

// >>> tb_phase_config_and_pg_delay_regs.sv
// Self-checking bench for the phase configuration bank.
// Assumes the host model and checker compile first.
`timescale 1ns/1ps
`include "phase_cfg_regs.svh"
module tb_phase_config_and_pg_delay_regs;
  logic clk_i, resetn_i, wr_en_i, rd_valid_o, strap_preset_i, above_pg_thresh_i, enable_i;
  logic power_good_pin_o, fast_adaptive_loop_o, multiphase_mode_o, soft_off_allowed_o;
  logic high_side_drive_out_o, high_side_drive_oe_o, low_side_drive_output_o;
  logic ramp_active_o, ramp_step_o;
  logic [7:0] wr_cmd_i, rd_cmd_i;
  logic [15:0] wr_data_i, rd_data_o, strap_rail_cfg_i, input_current_cal_o;
  logic [6:0] bus_addr_i;
  logic [2:0] phase_slot_o;
  logic [3:0] phase_total_o;
  int num_errors = 0;
  int tests_run = 0;
  int n;
  // Short ramp base keeps start-up brief
  phase_config_and_pg_delay_regs #(.RAMP_BASE_CYCLES(64)) i_dut (.clk_i, .resetn_i, .wr_en_i,
    .wr_cmd_i, .wr_data_i, .rd_cmd_i, .rd_data_o, .rd_valid_o, .bus_addr_i, .strap_preset_i,
    .strap_rail_cfg_i, .above_pg_thresh_i, .enable_i, .power_good_pin_o, .fast_adaptive_loop_o,
    .multiphase_mode_o, .soft_off_allowed_o, .high_side_drive_out_o, .high_side_drive_oe_o,
    .low_side_drive_output_o, .ramp_active_o, .ramp_step_o, .phase_slot_o, .phase_total_o,
    .input_current_cal_o);
  phase_cfg_host i_host (.clk_i, .wr_en_o(wr_en_i), .wr_cmd_o(wr_cmd_i), .wr_data_o(wr_data_i),
    .rd_cmd_o(rd_cmd_i), .rd_data_i(rd_data_o));
  // 200 MHz clock
  initial begin
    clk_i = 1'b0;
    forever #2.5 clk_i = ~clk_i;
  end
  task automatic summarize();
    $display("checks %0d mismatches %0d", tests_run, num_errors);
    if (num_errors == 0 && tests_run > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  task automatic cmp16(input string what, input logic [15:0] exp, input logic [15:0] got);
    tests_run++;
    if (got !== exp) begin
      num_errors++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic cmp1(input string what, input logic exp, input logic got);
    cmp16(what, {15'h0000, exp}, {15'h0000, got});
  endtask
  task automatic chk_rd(input string what, input logic [7:0] cmd, input logic [15:0] exp);
    logic [15:0] got;
    i_host.rd(cmd, got);
    cmp16(what, exp, got);
  endtask
  task automatic do_reset(input logic pre);
    resetn_i <= 1'b0;
    strap_preset_i <= pre;
    repeat (20) @(posedge clk_i);
    resetn_i <= 1'b1;
    repeat (2) @(posedge clk_i);
  endtask
  // Cycles until power good; a spent bound ends the run
  task automatic wait_pg(input int lim);
    n = 0;
    while (power_good_pin_o !== 1'b1 && n < lim) begin
      @(negedge clk_i);
      n++;
    end
    if (n >= lim) begin
      num_errors++;
      $display("[FAIL] power good wait expected rise seen none");
      summarize();
    end
  endtask
  task automatic t_defaults();
    chk_rd("cal default", `OFS_IIN_CAL, `RST_IIN_CAL);
    chk_rd("rail default", `OFS_RAIL_CFG, 16'h1A00);
    chk_rd("pg delay default", `OFS_PG_DELAY, `RST_PG_DELAY);
    chk_rd("gain default", `OFS_RAMP_GAIN, {8'h00, `RST_RAMP_GAIN});
    chk_rd("unmapped read", 8'hD6, 16'h0000);
    cmp1("unmapped valid", 1'b0, rd_valid_o);
    $display("test defaults done");
  endtask
  // All ones everywhere shows each register's live bits
  task automatic t_rw();
    i_host.wr(`OFS_IIN_CAL, 16'hFFFF);
    i_host.wr(`OFS_RAIL_CFG, 16'hFFFF);
    i_host.wr(`OFS_PG_DELAY, 16'hFFFF);
    i_host.wr(`OFS_RAMP_GAIN, 16'hFFFF);
    i_host.wr(8'hD6, 16'h0000);
    chk_rd("cal rw", `OFS_IIN_CAL, 16'hFFFF);
    cmp16("cal out", 16'hFFFF, input_current_cal_o);
    chk_rd("rail rw", `OFS_RAIL_CFG, 16'hFF07);
    cmp16("phase total", 16'h0008, {12'h000, phase_total_o});
    chk_rd("pg delay rw", `OFS_PG_DELAY, 16'hFFFF);
    chk_rd("gain rw", `OFS_RAMP_GAIN, 16'h00FF);
    $display("test read write done");
  endtask
  task automatic t_pg();
    i_host.wr(`OFS_PG_DELAY, 16'hB808); // 8 * 2^-9 ms is 125 ticks
    enable_i <= 1'b1;
    above_pg_thresh_i <= 1'b1;
    wait_pg(4000);
    // First tick lands anywhere in its 25-cycle slot, so allow one tick early
    cmp1("pg delay", 1'b1, n >= 3100 && n <= 3140);
    above_pg_thresh_i <= 1'b0;
    repeat (8) @(negedge clk_i);
    cmp1("pg drop", 1'b0, power_good_pin_o);
    above_pg_thresh_i <= 1'b1;
    repeat (2000) @(negedge clk_i);
    above_pg_thresh_i <= 1'b0;
    repeat (10) @(negedge clk_i);
    above_pg_thresh_i <= 1'b1;
    wait_pg(4000);
    cmp1("pg restart", 1'b1, n >= 3100);
    above_pg_thresh_i <= 1'b0;
    i_host.wr(`OFS_PG_DELAY, 16'h0000);
    repeat (8) @(negedge clk_i);
    above_pg_thresh_i <= 1'b1;
    wait_pg(40);
    cmp1("pg zero delay", 1'b1, n <= 10);
    $display("test pg delay done");
  endtask
  task automatic t_two_phase();
    i_host.set_rail(3'h0, 5'h05, 3'h1);
    i_host.set_rail(3'h1, 5'h05, 3'h1);
    @(negedge clk_i);
    cmp1("two phase mode", 1'b0, multiphase_mode_o);
    cmp1("fast loop standalone", 1'b1, fast_adaptive_loop_o);
    enable_i <= 1'b0;
    repeat (8) @(negedge clk_i);
    cmp1("soft off drives high", 1'b0, high_side_drive_oe_o);
    above_pg_thresh_i <= 1'b0;
    repeat (8) @(negedge clk_i);
    $display("test two phase done");
  endtask
  task automatic t_four_phase();
    i_host.set_rail(3'h2, 5'h05, 3'h3);
    i_host.wr(`OFS_PG_DELAY, 16'hB808);
    @(negedge clk_i);
    cmp1("four phase mode", 1'b1, multiphase_mode_o);
    cmp1("soft off barred", 1'b0, soft_off_allowed_o);
    cmp16("phase slot", 16'h0002, {13'h0000, phase_slot_o});
    enable_i <= 1'b1;
    repeat (20) @(negedge clk_i);
    cmp1("fast loop in ramp", 1'b0, fast_adaptive_loop_o);
    cmp1("ramp running", 1'b1, ramp_active_o);
    above_pg_thresh_i <= 1'b1;
    wait_pg(4000);
    repeat (4) @(negedge clk_i);
    cmp1("fast loop after pg", 1'b1, fast_adaptive_loop_o);
    enable_i <= 1'b0;
    repeat (8) @(negedge clk_i);
    cmp1("high side floats", 1'b1, high_side_drive_oe_o);
    cmp1("low side low", 1'b0, low_side_drive_output_o);
    above_pg_thresh_i <= 1'b0;
    $display("test four phase done");
  endtask
  // Second reset in mid-run with the strap preset chosen
  task automatic t_strap();
    do_reset(1'b1);
    chk_rd("strap rail", `OFS_RAIL_CFG, 16'h4101);
    $display("test strap done");
  endtask
  // Main sequence
  initial begin
    resetn_i = 1'b0;
    above_pg_thresh_i = 1'b0;
    enable_i = 1'b0;
    bus_addr_i = 7'h5A;
    strap_preset_i = 1'b0;
    strap_rail_cfg_i = 16'h4101;
    do_reset(1'b0);
    t_defaults();
    t_rw();
    t_pg();
    t_two_phase();
    t_four_phase();
    t_strap();
    summarize();
  end
endmodule // tb_phase_config_and_pg_delay_regs
bind phase_config_and_pg_delay_regs phase_cfg_asserts i_chk (.clk_i, .resetn_i, .rd_cmd_i,
  .rd_data_o, .above_pg_thresh_i, .enable_i, .power_good_pin_o, .fast_adaptive_loop_o,
  .multiphase_mode_o, .soft_off_allowed_o, .high_side_drive_oe_o, .low_side_drive_output_o,
  .ramp_active_o, .phase_slot_o, .phase_total_o);
